// ### cod_pkg.sv
// Shared constants for the operand address decode unit: field layout,
// class and operation encodings, state codes and address limits.
// Assumes a single 20 MHz clock domain and a 16-bit word memory port.
`default_nettype none

package cod_pkg;

  // Instruction word field positions.
  localparam int CLASS_HI   = 15;
  localparam int CLASS_LO   = 12;
  localparam int WIDTH_BIT  = 11;
  localparam int OP_HI      = 10;
  localparam int OP_LO      = 8;
  localparam int IND_BIT    = 7;
  localparam int ACC_HI     = 6;
  localparam int ACC_LO     = 4;
  localparam int EXT_BIT    = 3;
  localparam int IDX_HI     = 2;
  localparam int IDX_LO     = 0;
  localparam int DISP_HI    = 7;
  localparam int TEST_HI    = 11;
  localparam int TEST_LO    = 8;
  localparam int CREL_BIT   = 11;

  // Instruction classes; one through seven are the general register group.
  localparam logic [3:0] CLASS_REG     = 4'h1;
  localparam logic [3:0] CLASS_MEM2REG = 4'h2;
  localparam logic [3:0] CLASS_REG2MEM = 4'h3;
  localparam logic [3:0] CLASS_IMM     = 4'h4;
  localparam logic [3:0] CLASS_AUTOINC = 4'h5;
  localparam logic [3:0] CLASS_AUTODEC = 4'h6;
  localparam logic [3:0] CLASS_IMMREG  = 4'h7;
  localparam logic [3:0] CLASS_BRANCH  = 4'h8;
  localparam logic [3:0] CLASS_CTRL    = 4'h9;

  // Branch tests and control sub-operations.
  localparam logic [3:0] TEST_ALWAYS = 4'h0;
  localparam logic [3:0] TEST_EQUAL  = 4'h1;
  localparam logic [2:0] CTRL_RETURN_FROM_INTERRUPT   = 3'h0;

  // Operation field codes.
  localparam logic [2:0] OP_MOVE = 3'h0;
  localparam logic [2:0] OP_SUB  = 3'h1;
  localparam logic [2:0] OP_ADD  = 3'h2;
  localparam logic [2:0] OP_AND  = 3'h3;
  localparam logic [2:0] OP_OR   = 3'h4;
  localparam logic [2:0] OP_XOR  = 3'h5;
  localparam logic [2:0] OP_CMP  = 3'h6;
  localparam logic [2:0] OP_TST  = 3'h7;

  // Address map, reset values and limits.
  localparam logic [15:0] MODULE_SPACE_BASE = 16'hf800;
  localparam logic [15:0] ABS_AREA_LIMIT    = 16'h0200;
  localparam logic [15:0] PC_RESET          = 16'h0000;
  localparam logic [15:0] STATUS_RESET      = 16'h0000;
  localparam logic [15:0] WORD_STEP         = 16'h0002;
  localparam logic [15:0] BYTE_STEP         = 16'h0001;
  localparam logic [15:0] EXT_PC_STEP       = 16'h0004;
  localparam logic [3:0]  IND_LEVEL_MAX     = 4'he;
  localparam int          STATUS_EQ_BIT     = 0;

  // Sequencer states, one-hot.
  typedef enum logic [8:0] {
    ST_IDLE = 9'b000000001,
    ST_EXT  = 9'b000000010,
    ST_ADDR = 9'b000000100,
    ST_IND  = 9'b000001000,
    ST_OPER = 9'b000010000,
    ST_EXEC = 9'b000100000,
    ST_WR   = 9'b001000000,
    ST_RST  = 9'b010000000,
    ST_RPC  = 9'b100000000
  } cod_state_e;

endpackage

`default_nettype wire

// ### cod_operand_decode.sv
// Instruction decode, operand address generation and execution sequencer.
// Assumes one memory port that holds a request until a one-cycle ack.
//
// Function
// - Operand byte addresses span the full 16-bit space.
// - Top 2K byte addresses are module register space, flagged as such.
// - Words sit at even addresses and are fetched in one memory access.
// - Byte operations use the high byte for even, low for odd addresses.
// - Branch displacement is signed, minus 128 to plus 127 words.
// - Branch-if-equal jumps when equal flag set, otherwise falls through.
// - Branch target is program counter plus twice the displacement.
// - Control group takes absolute low 256 words or PC-relative address.
// - Return loads status from computed location, then PC from two above.
// - General word: class, width, op, indirect, accumulator, extend, index.
// - General classes provide direct, indexed, auto, indirect, register, immediate.
// - Registers one to seven index; register zero is the program counter.
// - One-word immediate constant 0 to 15 combines into the accumulator.
// - Op code one is subtract; class three is register-to-memory.
// - Extended flag fetches the next word as extension address.
// - Odd word-mode pointers chain; fourteen levels raise unimplemented interrupt.
// - Direct-indexed address is extension word plus index register.
`default_nettype none

module cod_operand_decode
  import cod_pkg::*;
(
  input  wire logic        i_clock,        // System clock, 20 MHz.
  input  wire logic        i_nrst,         // Asynchronous reset, active low.
  input  wire logic        i_instr_valid,  // Instruction word present, taken when idle.
  input  wire logic [15:0] i_instr,        // Instruction word at the program counter.
  input  wire logic        i_mem_ack,      // Memory access complete, one cycle.
  input  wire logic [15:0] i_mem_rdata,    // Read word, valid with the ack.
  output logic             o_mem_req,      // Memory request, held until ack.
  output logic             o_mem_we,       // Request is a write.
  output logic      [15:0] o_mem_addr,     // Even word byte address.
  output logic      [15:0] o_mem_wdata,    // Write word.
  output logic      [15:0] o_pc,           // Program counter.
  output logic      [15:0] o_status,       // Processor status word.
  output logic             o_busy,         // Instruction in progress.
  output logic             o_done,         // Instruction finished, one cycle.
  output logic             o_unimpl_irq,   // Unimplemented instruction event, one cycle.
  output logic      [15:0] o_eff_addr,     // Last effective byte address.
  output logic             o_module_space  // Last effective address in module space.
);

  cod_state_e  state;
  logic [15:0] ir;
  logic [15:0] ext;
  logic [15:0] loc;
  logic [15:0] operand;
  logic [15:0] mem_word;
  logic [15:0] gpr [1:7];
  logic [3:0]  level;
  logic        ext_used;

  // Decode of the incoming word for single-cycle branch and control handling.
  logic [3:0]  in_cls;
  logic [15:0] pc_plus2;
  logic [15:0] brn_target;
  logic [15:0] ctrl_loc;
  logic        in_general;
  logic        brn_taken;

  always_comb begin
    in_cls     = i_instr[CLASS_HI:CLASS_LO];
    pc_plus2   = o_pc + WORD_STEP;
    // Sign-extended word displacement doubled into bytes.
    brn_target = o_pc + {{7{i_instr[DISP_HI]}}, i_instr[DISP_HI:0], 1'b0};
    // Absolute form reaches only the lowest 256 words.
    ctrl_loc   = i_instr[CREL_BIT] ? brn_target : {7'h00, i_instr[DISP_HI:0], 1'b0};
    in_general = (in_cls >= CLASS_REG) && (in_cls <= CLASS_IMMREG);
    brn_taken  = (i_instr[TEST_HI:TEST_LO] == TEST_ALWAYS) ||
                 ((i_instr[TEST_HI:TEST_LO] == TEST_EQUAL) && o_status[STATUS_EQ_BIT]);
  end

  // Field split of the held general register instruction.
  logic [3:0]  cls;
  logic        wbyte;
  logic [2:0]  op;
  logic        ind;
  logic [2:0]  acc;
  logic        ebit;
  logic [2:0]  xr;

  always_comb begin
    cls   = ir[CLASS_HI:CLASS_LO];
    wbyte = ir[WIDTH_BIT];
    op    = ir[OP_HI:OP_LO];
    ind   = ir[IND_BIT];
    acc   = ir[ACC_HI:ACC_LO];
    ebit  = ir[EXT_BIT];
    xr    = ir[IDX_HI:IDX_LO];
  end

  // Register zero reads as the program counter.
  function automatic logic [15:0] read_reg(input logic [2:0] sel);
    if (sel == 3'h0) begin
      read_reg = o_pc;
    end else begin
      read_reg = gpr[sel];
    end
  endfunction

  // Address arithmetic: extension plus signed index, with auto step.
  logic [15:0] xval;
  logic [15:0] aval;
  logic [15:0] base;
  logic [15:0] idxv;
  logic [15:0] step;
  logic [15:0] addr_sum;
  logic [15:0] dec_sum;
  logic [15:0] loc_sel;
  logic [15:0] pc_seq;

  always_comb begin
    xval     = read_reg(xr);
    aval     = read_reg(acc);
    base     = ebit ? ext : 16'h0000;
    idxv     = (xr != 3'h0) ? xval : 16'h0000;
    step     = wbyte ? BYTE_STEP : WORD_STEP;
    addr_sum = base + idxv;
    dec_sum  = addr_sum - step;
    loc_sel  = (cls == CLASS_AUTODEC) ? dec_sum : addr_sum;
    pc_seq   = o_pc + (ext_used ? EXT_PC_STEP : WORD_STEP);
  end

  // Operation unit; register-to-memory makes memory the destination.
  logic [15:0] dst;
  logic [15:0] src;
  logic [15:0] res;
  logic        res_zero;
  logic        writes;
  logic [15:0] mem_merge;
  logic [15:0] reg_merge;

  always_comb begin
    dst = (cls == CLASS_REG2MEM) ? operand : aval;
    src = (cls == CLASS_REG2MEM) ? aval : operand;
    unique case (op)
      OP_MOVE: res = src;
      OP_SUB:  res = dst - src;
      OP_ADD:  res = dst + src;
      OP_AND:  res = dst & src;
      OP_OR:   res = dst | src;
      OP_XOR:  res = dst ^ src;
      OP_CMP:  res = dst - src;
      OP_TST:  res = dst & src;
    endcase
    res_zero  = wbyte ? (res[7:0] == 8'h00) : (res == 16'h0000);
    writes    = (op != OP_CMP) && (op != OP_TST);
    // Byte result goes back into its own lane of the fetched word.
    if (!wbyte) begin
      mem_merge = res;
    end else if (loc[0]) begin
      mem_merge = {mem_word[15:8], res[7:0]};
    end else begin
      mem_merge = {res[7:0], mem_word[7:0]};
    end
    reg_merge = wbyte ? {dst[15:8], res[7:0]} : res;
  end

  // Sequencer: fetches, address formation, execution and program counter.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state          <= ST_IDLE;
      ir             <= 16'h0000;
      ext            <= 16'h0000;
      loc            <= 16'h0000;
      operand        <= 16'h0000;
      mem_word       <= 16'h0000;
      level          <= 4'h0;
      ext_used       <= 1'b0;
      for (int i = 1; i <= 7; i++) begin
        gpr[i] <= 16'h0000;
      end
      o_mem_req      <= 1'b0;
      o_mem_we       <= 1'b0;
      o_mem_addr     <= 16'h0000;
      o_mem_wdata    <= 16'h0000;
      o_pc           <= PC_RESET;
      o_status       <= STATUS_RESET;
      o_busy         <= 1'b0;
      o_done         <= 1'b0;
      o_unimpl_irq   <= 1'b0;
      o_eff_addr     <= 16'h0000;
      o_module_space <= 1'b0;
    end else begin
      o_done       <= 1'b0;
      o_unimpl_irq <= 1'b0;
      if (i_mem_ack) begin
        o_mem_req <= 1'b0;
        o_mem_we  <= 1'b0;
      end
      unique case (state)
        ST_IDLE: begin
          if (i_instr_valid) begin
            ir       <= i_instr;
            ext_used <= 1'b0;
            if (in_cls == CLASS_BRANCH) begin
              o_pc   <= brn_taken ? brn_target : pc_plus2;
              o_done <= 1'b1;
            end else if (in_cls == CLASS_CTRL && i_instr[OP_HI:OP_LO] == CTRL_RETURN_FROM_INTERRUPT) begin
              o_mem_req  <= 1'b1;
              o_mem_addr <= {ctrl_loc[15:1], 1'b0};
              o_eff_addr <= ctrl_loc;
              o_module_space <= (ctrl_loc >= MODULE_SPACE_BASE);
              o_busy     <= 1'b1;
              state      <= ST_RST;
            end else if (in_general && i_instr[EXT_BIT] && in_cls != CLASS_IMM) begin
              ext_used   <= 1'b1;
              o_mem_req  <= 1'b1;
              o_mem_addr <= pc_plus2;
              o_busy     <= 1'b1;
              state      <= ST_EXT;
            end else if (in_general) begin
              o_busy <= 1'b1;
              state  <= ST_ADDR;
            end else begin
              o_pc         <= pc_plus2;
              o_unimpl_irq <= 1'b1;
            end
          end
        end
        ST_EXT: begin
          if (i_mem_ack) begin
            ext   <= i_mem_rdata;
            state <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (cls == CLASS_REG) begin
            operand <= xval;
            loc     <= 16'h0000;
            state   <= ST_EXEC;
          end else if (cls == CLASS_IMM) begin
            // Constant 0 to 15 sits in the low nibble of the word.
            operand <= {12'h000, ir[EXT_BIT:IDX_LO]};
            loc     <= 16'h0000;
            state   <= ST_EXEC;
          end else if (cls == CLASS_IMMREG) begin
            operand <= addr_sum;
            loc     <= 16'h0000;
            state   <= ST_EXEC;
          end else begin
            if (xr != 3'h0 && cls == CLASS_AUTOINC) begin
              gpr[xr] <= xval + step;
            end else if (xr != 3'h0 && cls == CLASS_AUTODEC) begin
              gpr[xr] <= xval - step;
            end
            loc        <= loc_sel;
            level      <= ind ? 4'h1 : 4'h0;
            o_mem_req  <= 1'b1;
            o_mem_addr <= {loc_sel[15:1], 1'b0};
            state      <= ind ? ST_IND : ST_OPER;
          end
        end
        ST_IND: begin
          if (i_mem_ack) begin
            if (!wbyte && i_mem_rdata[0]) begin
              if (level == IND_LEVEL_MAX) begin
                o_unimpl_irq <= 1'b1;
                o_pc         <= pc_seq;
                o_busy       <= 1'b0;
                state        <= ST_IDLE;
              end else begin
                level      <= level + 4'h1;
                o_mem_req  <= 1'b1;
                o_mem_addr <= {i_mem_rdata[15:1], 1'b0};
              end
            end else begin
              loc        <= i_mem_rdata;
              o_mem_req  <= 1'b1;
              o_mem_addr <= {i_mem_rdata[15:1], 1'b0};
              state      <= ST_OPER;
            end
          end
        end
        ST_OPER: begin
          if (i_mem_ack) begin
            mem_word <= i_mem_rdata;
            if (wbyte) begin
              operand <= {8'h00, loc[0] ? i_mem_rdata[7:0] : i_mem_rdata[15:8]};
            end else begin
              operand <= i_mem_rdata;
            end
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (!writes) begin
            o_status[STATUS_EQ_BIT] <= res_zero;
          end
          o_eff_addr     <= loc;
          o_module_space <= (loc >= MODULE_SPACE_BASE);
          if (writes && cls == CLASS_REG2MEM) begin
            o_mem_req   <= 1'b1;
            o_mem_we    <= 1'b1;
            o_mem_addr  <= {loc[15:1], 1'b0};
            o_mem_wdata <= mem_merge;
            state       <= ST_WR;
          end else begin
            if (writes && acc != 3'h0) begin
              gpr[acc] <= reg_merge;
            end
            o_pc   <= pc_seq;
            o_done <= 1'b1;
            o_busy <= 1'b0;
            state  <= ST_IDLE;
          end
        end
        ST_WR: begin
          if (i_mem_ack) begin
            o_pc   <= pc_seq;
            o_done <= 1'b1;
            o_busy <= 1'b0;
            state  <= ST_IDLE;
          end
        end
        ST_RST: begin
          if (i_mem_ack) begin
            o_status   <= i_mem_rdata;
            o_mem_req  <= 1'b1;
            o_mem_addr <= o_mem_addr + WORD_STEP;
            state      <= ST_RPC;
          end
        end
        ST_RPC: begin
          if (i_mem_ack) begin
            o_pc   <= i_mem_rdata;
            o_done <= 1'b1;
            o_busy <= 1'b0;
            state  <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Checks on the sequencer and address formation.
  logic take_branch;
  logic take_return_from_interrupt_abs;
  logic take_ext;

  always_comb begin
    take_branch   = (state == ST_IDLE) && i_instr_valid && (in_cls == CLASS_BRANCH);
    take_return_from_interrupt_abs = (state == ST_IDLE) && i_instr_valid && (in_cls == CLASS_CTRL) &&
                    (i_instr[OP_HI:OP_LO] == CTRL_RETURN_FROM_INTERRUPT) && !i_instr[CREL_BIT];
    take_ext      = (state == ST_IDLE) && i_instr_valid && in_general &&
                    i_instr[EXT_BIT] && (in_cls != CLASS_IMM);
  end

  chk_mem_word_align: assert property (@(posedge i_clock) disable iff (!i_nrst)
    o_mem_req |-> (o_mem_addr[0] == 1'b0))
    else $error("memory request at odd address");

  chk_module_space_flag: assert property (@(posedge i_clock) disable iff (!i_nrst)
    o_done |-> (o_module_space == (o_eff_addr >= MODULE_SPACE_BASE)))
    else $error("module space flag wrong");

  chk_branch_taken_pc: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (take_branch && brn_taken) |=> (o_pc == $past(brn_target) && o_done))
    else $error("taken branch target wrong");

  chk_branch_fall_pc: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (take_branch && !brn_taken) |=> (o_pc == $past(pc_plus2)))
    else $error("untaken branch did not fall through");

  chk_return_from_interrupt_second_word: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (state == ST_RST && i_mem_ack) |=>
      (state == ST_RPC && o_mem_req && o_mem_addr == $past(o_mem_addr) + WORD_STEP))
    else $error("return did not read word two above");

  chk_ctrl_abs_area: assert property (@(posedge i_clock) disable iff (!i_nrst)
    take_return_from_interrupt_abs |=> (o_mem_req && o_mem_addr < ABS_AREA_LIMIT))
    else $error("absolute control address outside low area");

  chk_ext_word_fetch: assert property (@(posedge i_clock) disable iff (!i_nrst)
    take_ext |=> (state == ST_EXT && o_mem_req && o_mem_addr == $past(pc_plus2)))
    else $error("extension word not fetched");

  chk_chain_level_max: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (state == ST_IND && i_mem_ack && !wbyte && i_mem_rdata[0] && level == IND_LEVEL_MAX)
      |=> (o_unimpl_irq && state == ST_IDLE && !o_busy))
    else $error("indirect chain limit not enforced");

  chk_return_from_interrupt_done_window: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (state == ST_RPC && i_mem_ack) |=> (o_done && o_pc == $past(i_mem_rdata)))
    else $error("return did not load program counter");

  cov_branch_taken: cover property (@(posedge i_clock) disable iff (!i_nrst)
    take_branch && brn_taken);
  cov_return_from_interrupt_complete: cover property (@(posedge i_clock) disable iff (!i_nrst)
    state == ST_RPC && i_mem_ack);
  cov_indirect_chain: cover property (@(posedge i_clock) disable iff (!i_nrst)
    state == ST_IND && level > 4'h2);
  cov_byte_mem_write: cover property (@(posedge i_clock) disable iff (!i_nrst)
    state == ST_WR && wbyte);

endmodule

`default_nettype wire

// ### cod_mem_model.sv
// Behavioural word memory on the far side of the operand memory port.
// Assumes one request at a time, held by the design until the ack.
`default_nettype none

module cod_mem_model (
  input  wire logic        i_clock,  // System clock.
  input  wire logic        i_nrst,   // Asynchronous reset, active low.
  input  wire logic        i_req,    // Request, held until ack.
  input  wire logic        i_we,     // Request is a write.
  input  wire logic [15:0] i_addr,   // Even byte address.
  input  wire logic [15:0] i_wdata,  // Word to store.
  input  wire logic [3:0]  i_lat,    // Wait cycles before the ack.
  output logic             o_ack,    // Access done, one cycle.
  output logic      [15:0] o_rdata   // Read word, valid with the ack only.
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [15:0] mem [0:32767];  // Word store, also loaded by the bench.
  logic [3:0]  wait_cnt;       // Cycles spent on the pending request.

  // Answers after the set wait; data lines toggle when idle, after an ack and on a write ack so a
  // late sample never finds a stale word.
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ack    <= 1'b0;
      wait_cnt <= 4'h0;
      o_rdata  <= 16'h0;
    end else if (o_ack || !i_req) begin
      o_ack    <= 1'b0;
      wait_cnt <= 4'h0;
      o_rdata  <= ~o_rdata;
    end else if (wait_cnt >= i_lat) begin
      o_ack <= 1'b1;
      if (i_we) begin
        mem[i_addr[15:1]] <= i_wdata;
        o_rdata           <= ~o_rdata;
      end else begin
        o_rdata <= mem[i_addr[15:1]];
      end
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end

endmodule

`default_nettype wire

// ### cod_operand_decode_tb.sv
// Self-checking bench for the operand address decode unit.
// Assumes the memory model answers every request and the bench supplies words at the pc.
`default_nettype none

module cod_operand_decode_tb
  import cod_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {
    logic [15:0] ins, ext, pc, eff;
    logic        st;
    logic [2:0]  fl;
  } cod_row_s;

  logic        clock = 1'b0;
  logic        nrst  = 1'b0;
  logic        valid = 1'b0;
  logic [15:0] instr = 16'h0;
  logic [3:0]  lat   = 4'h0;
  logic        ack, req, we, busy, done, irq, mod, irq_seen;
  logic [15:0] rdata, addr, wdata, pc, status, eff, a, ind;
  int          error_cnt = 0;
  int          tests_run = 0;
  cod_row_s    rows[$];
  logic [15:0] ops_exp[8] = '{16'h0003, 16'h0003, 16'h0009, 16'h0002,
                              16'h0007, 16'h0005, 16'h0006, 16'h0006};
  logic [15:0] mem_exp[12] = '{16'h0100, 16'h0014, 16'hf7fe, 16'h0014, 16'hf800, 16'h0014,
                               16'h0120, 16'h001c, 16'h0140, 16'h00cd, 16'h0142, 16'h00ab};

  // Free-running 20 MHz clock.
  always #25 clock = ~clock;

  cod_operand_decode DUT (
    .i_clock(clock), .i_nrst(nrst), .i_instr_valid(valid), .i_instr(instr),
    .i_mem_ack(ack), .i_mem_rdata(rdata), .o_mem_req(req), .o_mem_we(we),
    .o_mem_addr(addr), .o_mem_wdata(wdata), .o_pc(pc), .o_status(status),
    .o_busy(busy), .o_done(done), .o_unimpl_irq(irq), .o_eff_addr(eff),
    .o_module_space(mod)
  );

  cod_mem_model u_mem (
    .i_clock(clock), .i_nrst(nrst), .i_req(req), .i_we(we), .i_addr(addr),
    .i_wdata(wdata), .i_lat(lat), .o_ack(ack), .o_rdata(rdata)
  );

  // Builds a general register instruction word with the indirect bit clear.
  function automatic logic [15:0] gw(input logic [3:0] c, input logic b, input logic [2:0] op,
                                     input logic [2:0] acc, input logic e, input logic [2:0] xr);
    return {c, b, op, 1'b0, acc, e, xr};
  endfunction

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic tally_and_finish();
    if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Queues one table row.
  task automatic add(input logic [15:0] ins, ext, p, e, input logic s, input logic [2:0] f);
    rows.push_back('{ins, ext, p, e, s, f});
  endtask

  // Places the extension word, offers one instruction and waits for its end.
  task automatic exec(input logic [15:0] ins, input logic [15:0] ext);
    logic [15:0] nx;
    int          n;
    n = 0;
    nx = pc + 16'h0002;
    u_mem.mem[nx[15:1]] = ext;
    while (busy !== 1'b0 && n < 300) begin
      @(posedge clock);
      #1;
      n++;
    end
    @(posedge clock);
    valid <= 1'b1;
    instr <= ins;
    @(posedge clock);
    valid <= 1'b0;
    #1;
    while (done !== 1'b1 && irq !== 1'b1 && n < 300) begin
      @(posedge clock);
      #1;
      n++;
    end
    irq_seen = irq;
    check(16'(n < 300), 16'h0001);
  endtask

  // Watchdog sized well beyond the roughly 520 cycles the sequence needs.
  initial begin
    #1000000;
    error_cnt++;
    tally_and_finish();
  end

  // Main sequence: reset, table of ordinary cases, then the awkward cases.
  initial begin
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    #1;
    check(pc, PC_RESET);
    check(status, STATUS_RESET);
    check({13'h0, busy, done, req}, 16'h0);
    u_mem.mem[15'h0090] = 16'h0030;
    u_mem.mem[15'h0098] = 16'habcd;
    // Rows: instruction, extension, pc, effective address, equal flag, {eff?, module, irq}.
    add(gw(CLASS_IMM, 1'b0, OP_MOVE, 3'h1, 1'b0, 3'h5), 16'h0, 16'h0002, 16'h0, 1'b0, 3'h4);
    add(gw(CLASS_IMM, 1'b0, OP_ADD, 3'h1, 1'b1, 3'h7), 16'h0, 16'h0004, 16'h0, 1'b0, 3'h4);
    add(gw(CLASS_IMM, 1'b0, OP_MOVE, 3'h2, 1'b0, 3'h0), 16'h0, 16'h0006, 16'h0, 1'b0, 3'h4);
    add(gw(CLASS_IMM, 1'b0, OP_MOVE, 3'h3, 1'b0, 3'h0), 16'h0, 16'h0008, 16'h0, 1'b0, 3'h4);
    add(gw(CLASS_REG2MEM, 1'b0, OP_MOVE, 3'h1, 1'b1, 3'h0),
        16'h0100, 16'h000c, 16'h0100, 1'b0, 3'h4);
    add(gw(CLASS_REG2MEM, 1'b0, OP_MOVE, 3'h1, 1'b1, 3'h1),
        16'hf7ea, 16'h0010, 16'hf7fe, 1'b0, 3'h4);
    add(gw(CLASS_REG2MEM, 1'b0, OP_MOVE, 3'h1, 1'b1, 3'h1),
        16'hf7ec, 16'h0014, 16'hf800, 1'b0, 3'h6);
    add(gw(CLASS_REG2MEM, 1'b0, OP_SUB, 3'h1, 1'b1, 3'h0),
        16'h0120, 16'h0018, 16'h0120, 1'b0, 3'h4);
    add(gw(CLASS_MEM2REG, 1'b1, OP_MOVE, 3'h2, 1'b1, 3'h0),
        16'h0131, 16'h001c, 16'h0131, 1'b0, 3'h4);
    add(gw(CLASS_MEM2REG, 1'b1, OP_MOVE, 3'h3, 1'b1, 3'h0),
        16'h0130, 16'h0020, 16'h0130, 1'b0, 3'h4);
    add(gw(CLASS_REG2MEM, 1'b0, OP_MOVE, 3'h2, 1'b1, 3'h0),
        16'h0140, 16'h0024, 16'h0140, 1'b0, 3'h4);
    add(gw(CLASS_REG2MEM, 1'b0, OP_MOVE, 3'h3, 1'b1, 3'h0),
        16'h0142, 16'h0028, 16'h0142, 1'b0, 3'h4);
    add(gw(CLASS_REG, 1'b0, OP_CMP, 3'h1, 1'b0, 3'h1), 16'h0, 16'h002a, 16'h0, 1'b1, 3'h4);
    add({CLASS_BRANCH, TEST_EQUAL, 8'h7f}, 16'h0, 16'h0128, 16'h0, 1'b1, 3'h0);
    add({CLASS_BRANCH, TEST_ALWAYS, 8'h80}, 16'h0, 16'h0028, 16'h0, 1'b1, 3'h0);
    add(gw(CLASS_REG, 1'b0, OP_CMP, 3'h1, 1'b0, 3'h2), 16'h0, 16'h002a, 16'h0, 1'b0, 3'h4);
    add({CLASS_BRANCH, TEST_EQUAL, 8'h7f}, 16'h0, 16'h002c, 16'h0, 1'b0, 3'h0);
    add(16'hf000, 16'h0, 16'h002e, 16'h0, 1'b0, 3'h1);
    add({CLASS_BRANCH, 4'h2, 8'h10}, 16'h0, 16'h0030, 16'h0, 1'b0, 3'h0);
    add({CLASS_CTRL, 1'b0, 3'h1, 8'h00}, 16'h0, 16'h0032, 16'h0, 1'b0, 3'h1);
    foreach (rows[i]) begin
      exec(rows[i].ins, rows[i].ext);
      check(pc, rows[i].pc);
      check(status, {15'h0, rows[i].st});
      check(16'(irq_seen), 16'(rows[i].fl[0]));
      if (rows[i].fl[2]) begin
        check(eff, rows[i].eff);
        check(16'(mod), 16'(rows[i].fl[1]));
      end
    end
    for (int j = 0; j < 12; j += 2) begin
      a = mem_exp[j];
      check(u_mem.mem[a[15:1]], mem_exp[j + 1]);
    end
    // Every operation code on the accumulator, with a stalling memory.
    @(posedge clock) lat <= 4'h2;
    for (int op = 0; op < 8; op++) begin
      a = 16'h0160 + 16'(2 * op);
      exec(gw(CLASS_IMM, 1'b0, OP_MOVE, 3'h4, 1'b0, 3'h6), 16'h0);
      exec(gw(CLASS_IMM, 1'b0, 3'(op), 3'h4, 1'b0, 3'h3), 16'h0);
      exec(gw(CLASS_REG2MEM, 1'b0, OP_MOVE, 3'h4, 1'b1, 3'h0), a);
      check(u_mem.mem[a[15:1]], ops_exp[op]);
    end
    // Pointer chains: a short one, one that hits the level limit, one just under it.
    @(posedge clock) lat <= 4'h1;
    ind = gw(CLASS_MEM2REG, 1'b0, OP_MOVE, 3'h5, 1'b1, 3'h0) | 16'h0080;
    u_mem.mem[15'h0180] = 16'h0311;
    u_mem.mem[15'h0188] = 16'h0320;
    u_mem.mem[15'h0190] = 16'h1234;
    exec(ind, 16'h0300);
    check(eff, 16'h0320);
    exec(gw(CLASS_REG2MEM, 1'b0, OP_MOVE, 3'h5, 1'b1, 3'h0), 16'h0330);
    check(u_mem.mem[15'h0198], 16'h1234);
    for (int k = 0; k < 15; k++) u_mem.mem[15'h01a0 + 15'(k)] = 16'h0343 + 16'(2 * k);
    u_mem.mem[15'h01ae] = 16'h0360;
    exec(ind, 16'h0340);
    check(16'(irq_seen), 16'h0001);
    exec(ind, 16'h0342);
    check(16'(irq_seen), 16'h0000);
    check(eff, 16'h0360);
    // Auto step, register plus constant, then a byte write into the odd lane.
    u_mem.mem[15'h0200] = 16'h1111;
    u_mem.mem[15'h0201] = 16'h2222;
    exec(gw(CLASS_AUTOINC, 1'b0, OP_MOVE, 3'h6, 1'b1, 3'h7), 16'h0400);
    check(eff, 16'h0400);
    exec(gw(CLASS_AUTODEC, 1'b0, OP_MOVE, 3'h5, 1'b1, 3'h7), 16'h0402);
    check(eff, 16'h0402);
    exec(gw(CLASS_IMMREG, 1'b0, OP_ADD, 3'h6, 1'b1, 3'h5), 16'h0010);
    exec(gw(CLASS_REG2MEM, 1'b1, OP_MOVE, 3'h6, 1'b1, 3'h7), 16'h0401);
    check(eff, 16'h0401);
    check(u_mem.mem[15'h0200], 16'h1143);
    exec(gw(CLASS_REG2MEM, 1'b0, OP_MOVE, 3'h6, 1'b1, 3'h0), 16'h0404);
    check(u_mem.mem[15'h0202], 16'h3343);
    // Return from interrupt, absolute then relative, with a slow memory.
    @(posedge clock) lat <= 4'h3;
    u_mem.mem[15'h00f0] = 16'h0001;
    u_mem.mem[15'h00f1] = 16'h0456;
    exec({CLASS_CTRL, 1'b0, CTRL_RETURN_FROM_INTERRUPT, 8'hf0}, 16'h0);
    check(status, 16'h0001);
    check(pc, 16'h0456);
    u_mem.mem[15'h023b] = 16'h0000;
    u_mem.mem[15'h023c] = 16'h0300;
    exec({CLASS_CTRL, 1'b1, CTRL_RETURN_FROM_INTERRUPT, 8'h10}, 16'h0);
    check(status, 16'h0000);
    check(pc, 16'h0300);
    tally_and_finish();
  end

endmodule

`default_nettype wire
